//--- hw/scia_pkg.sv
// package of constants and types for the servo comm input and alarm block
package scia_pkg;
    // register map: word address of the communication input word
    localparam logic [15:0] SCIA_COMM_IN_ADDR = 16'h0451;
    localparam logic [15:0] SCIA_COMM_IN_RESET = 16'h0000;
    localparam int SCIA_NUM_INPUTS = 16;
    // bit positions in the communication input word
    localparam int SCIA_BIT_SERVO_ON = 0;
    localparam int SCIA_BIT_PROP_CTRL = 1;
    localparam int SCIA_BIT_FWD_OT = 2;
    localparam int SCIA_BIT_REV_OT = 3;
    localparam int SCIA_BIT_FAULT_RST = 4;
    localparam int SCIA_BIT_DEV_CLR = 5;
    localparam int SCIA_BIT_POS_CL = 6;
    localparam int SCIA_BIT_NEG_CL = 7;
    localparam int SCIA_BIT_GAIN_SEL = 8;
    localparam int SCIA_BIT_POS_SEL0 = 9;
    localparam int SCIA_BIT_POS_SEL1 = 10;
    localparam int SCIA_BIT_POS_SEL2 = 11;
    localparam int SCIA_BIT_POS_REF = 12;
    localparam int SCIA_BIT_POS_START = 13;
    localparam int SCIA_BIT_POS_STEP = 14;
    localparam int SCIA_BIT_HOME_START = 15;
    // alarm codes
    localparam logic [6:0] SCIA_ALM_NONE = 7'h00;
    localparam logic [6:0] SCIA_ALM_ENC_ABC = 7'h01;
    localparam logic [6:0] SCIA_ALM_ENC_UVW = 7'h02;
    localparam logic [6:0] SCIA_ALM_OVERLOAD = 7'h03;
    localparam logic [6:0] SCIA_ALM_HALL_CODE = 7'h05;
    localparam logic [6:0] SCIA_ALM_BOOT = 7'h08;
    localparam logic [6:0] SCIA_ALM_LOCKED = 7'h09;
    localparam logic [6:0] SCIA_ALM_OVERVOLT = 7'h0b;
    localparam logic [6:0] SCIA_ALM_UNDERVOLT = 7'h0c;
    localparam logic [6:0] SCIA_ALM_OVERSPEED = 7'h0e;
    localparam logic [6:0] SCIA_ALM_DEV_OVF = 7'h0f;
    localparam logic [6:0] SCIA_ALM_DEV_BIG = 7'h10;
    localparam logic [6:0] SCIA_ALM_MODEL = 7'h14;
    // alarm source indices into the latch vector
    localparam int SCIA_NUM_ALM = 12;
    localparam int SCIA_SRC_ENC_ABC = 0;
    localparam int SCIA_SRC_ENC_UVW = 1;
    localparam int SCIA_SRC_OVERLOAD = 2;
    localparam int SCIA_SRC_HALL = 3;
    localparam int SCIA_SRC_BOOT = 4;
    localparam int SCIA_SRC_LOCKED = 5;
    localparam int SCIA_SRC_OVERVOLT = 6;
    localparam int SCIA_SRC_UNDERVOLT = 7;
    localparam int SCIA_SRC_OVERSPEED = 8;
    localparam int SCIA_SRC_DEV_OVF = 9;
    localparam int SCIA_SRC_DEV_BIG = 10;
    localparam int SCIA_SRC_MODEL = 11;
    // latched (non-clearable) sources: boot, locked rotor, over/under volt, model
    localparam logic [11:0] SCIA_LATCHED_MASK = 12'h8f0;
    // locked rotor speed threshold in rpm
    localparam logic [15:0] SCIA_LOCK_RPM = 16'h000a;
    // display axis prefix letters
    localparam logic [7:0] SCIA_AXIS_A = 8'h41;
    localparam logic [7:0] SCIA_AXIS_B = 8'h62;
    // locked rotor timer states
    typedef enum logic [1:0] {
        SCIA_LK_IDLE = 2'b00,
        SCIA_LK_TIMING = 2'b01,
        SCIA_LK_TRIP = 2'b11
    } scia_lock_state_type;
endpackage

//--- hw/scia_lock_timer.sv
// locked rotor detector: torque above limit and speed low for a set time
`timescale 1ns/100ps
module scia_lock_timer #(
    parameter int TIME_W = 24
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [15:0] torque,
    input wire logic [15:0] lock_torque,
    input wire logic [15:0] speed_abs,
    input wire logic [TIME_W-1:0] lock_cycles,
    output logic trip
);
    import scia_pkg::*;

    scia_lock_state_type state_reg; // detector state
    scia_lock_state_type state_next;
    logic [TIME_W-1:0] count_reg; // cycles spent in the stall condition
    logic [TIME_W-1:0] count_next;
    logic stall; // torque high and speed low together

    // stall condition, speed strictly below threshold
    assign stall = (torque > lock_torque) && (speed_abs < SCIA_LOCK_RPM);

    // next state and counter
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            SCIA_LK_IDLE: begin
                count_next = '0;
                if (stall) begin
                    state_next = SCIA_LK_TIMING;
                end
            end
            SCIA_LK_TIMING: begin
                if (!stall) begin
                    // condition broke, restart
                    state_next = SCIA_LK_IDLE;
                end else if (count_reg >= lock_cycles) begin
                    state_next = SCIA_LK_TRIP;
                end else begin
                    count_next = count_reg + 1'b1;
                end
            end
            SCIA_LK_TRIP: begin
                // trip stands while stall holds
                if (!stall) begin
                    state_next = SCIA_LK_IDLE;
                end
            end
            default: begin
                state_next = SCIA_LK_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SCIA_LK_IDLE;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    assign trip = (state_reg == SCIA_LK_TRIP);
endmodule

//--- hw/scia_top.sv
// communication input word, input selection and alarm logic of the servo drive
`timescale 1ns/100ps
module scia_top #(
    parameter int TIME_W = 24,
    parameter logic AXIS_B = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_ack,
    input wire logic [scia_pkg::SCIA_NUM_INPUTS-1:0] io_connector,
    input wire logic [scia_pkg::SCIA_NUM_INPUTS-1:0] assign_null,
    output logic [scia_pkg::SCIA_NUM_INPUTS-1:0] eff_inputs,
    input wire logic [15:0] torque,
    input wire logic [15:0] lock_torque,
    input wire logic [TIME_W-1:0] lock_cycles,
    input wire logic [15:0] speed_abs,
    input wire logic [15:0] rated_torque,
    input wire logic overload_tmo,
    input wire logic [15:0] speed_limit,
    input wire logic [31:0] pos_dev,
    input wire logic [31:0] dev_limit,
    input wire logic dev_ovf,
    input wire logic [2:0] hall_uvw,
    input wire logic enc_abc_lost,
    input wire logic enc_uvw_lost,
    input wire logic boot_fault,
    input wire logic overvolt,
    input wire logic undervolt,
    input wire logic model_fault,
    output logic fault_output,
    output logic coast_stop,
    output logic [6:0] alarm_code,
    output logic [7:0] axis_letter,
    output logic normal_status
);
    import scia_pkg::*;

    logic [15:0] comm_input_bits_reg; // communication input word
    logic [15:0] comm_input_bits_next;
    logic [15:0] reg_rdata_reg;
    logic [15:0] reg_rdata_next;
    logic reg_ack_reg;
    logic [15:0] eff_reg; // effective control inputs
    logic [15:0] eff_next;
    logic rst_in_reg; // previous fault reset level
    logic [SCIA_NUM_ALM-1:0] alm_reg; // latched alarms
    logic [SCIA_NUM_ALM-1:0] alm_next;
    logic [SCIA_NUM_ALM-1:0] cause; // live alarm causes
    logic fault_reg;
    logic [6:0] code_reg;
    logic [6:0] code_next;
    logic lock_trip;
    logic reset_edge;
    logic normal_reg; // registered normal status, high while no alarm is latched
    logic [7:0] axis_reg; // registered axis prefix letter
    // axis prefix letter, fixed per build
    localparam logic [7:0] AXIS_CODE = AXIS_B ? SCIA_AXIS_B : SCIA_AXIS_A;

    // code of a source index
    function automatic logic [6:0] src_code(input int idx);
        logic [6:0] c;
        c = SCIA_ALM_NONE;
        case (idx)
            SCIA_SRC_ENC_ABC: c = SCIA_ALM_ENC_ABC;
            SCIA_SRC_ENC_UVW: c = SCIA_ALM_ENC_UVW;
            SCIA_SRC_OVERLOAD: c = SCIA_ALM_OVERLOAD;
            SCIA_SRC_HALL: c = SCIA_ALM_HALL_CODE;
            SCIA_SRC_BOOT: c = SCIA_ALM_BOOT;
            SCIA_SRC_LOCKED: c = SCIA_ALM_LOCKED;
            SCIA_SRC_OVERVOLT: c = SCIA_ALM_OVERVOLT;
            SCIA_SRC_UNDERVOLT: c = SCIA_ALM_UNDERVOLT;
            SCIA_SRC_OVERSPEED: c = SCIA_ALM_OVERSPEED;
            SCIA_SRC_DEV_OVF: c = SCIA_ALM_DEV_OVF;
            SCIA_SRC_DEV_BIG: c = SCIA_ALM_DEV_BIG;
            SCIA_SRC_MODEL: c = SCIA_ALM_MODEL;
            default: c = SCIA_ALM_NONE;
        endcase
        return c;
    endfunction

    // locked rotor timing
    scia_lock_timer #(.TIME_W(TIME_W)) i_scia_lock_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .torque(torque),
        .lock_torque(lock_torque),
        .speed_abs(speed_abs),
        .lock_cycles(lock_cycles),
        .trip(lock_trip)
    );

    // register access: write, read with one-cycle answer, unmapped reads zero
    always_comb begin
        comm_input_bits_next = comm_input_bits_reg;
        reg_rdata_next = 16'h0000;
        if (reg_wr && reg_addr == SCIA_COMM_IN_ADDR) begin
            comm_input_bits_next = reg_wdata;
        end
        if (reg_rd && reg_addr == SCIA_COMM_IN_ADDR) begin
            reg_rdata_next = comm_input_bits_reg;
        end
    end

    // input selection per bit: comm bit only where assignment is null
    always_comb begin
        for (int i = 0; i < SCIA_NUM_INPUTS; i++) begin
            eff_next[i] = assign_null[i] ? comm_input_bits_reg[i] : io_connector[i];
        end
    end

    // reset edge on the effective fault reset input
    assign reset_edge = eff_reg[SCIA_BIT_FAULT_RST] && !rst_in_reg;

    // live causes
    always_comb begin
        cause = '0;
        cause[SCIA_SRC_ENC_ABC] = enc_abc_lost;
        cause[SCIA_SRC_ENC_UVW] = enc_uvw_lost;
        cause[SCIA_SRC_OVERLOAD] = overload_tmo && (torque > rated_torque);
        cause[SCIA_SRC_HALL] = (&hall_uvw) || !(|hall_uvw);
        cause[SCIA_SRC_BOOT] = boot_fault;
        cause[SCIA_SRC_LOCKED] = lock_trip;
        cause[SCIA_SRC_OVERVOLT] = overvolt;
        cause[SCIA_SRC_UNDERVOLT] = undervolt;
        cause[SCIA_SRC_OVERSPEED] = speed_abs > speed_limit;
        cause[SCIA_SRC_DEV_OVF] = dev_ovf;
        cause[SCIA_SRC_DEV_BIG] = pos_dev > dev_limit;
        cause[SCIA_SRC_MODEL] = model_fault;
    end

    // alarm latch: set wins over reset, latched codes never clear
    always_comb begin
        alm_next = alm_reg | cause;
        if (reset_edge) begin
            alm_next = (alm_reg & SCIA_LATCHED_MASK) | cause;
        end
    end

    // lowest-index active alarm selects the displayed code
    always_comb begin
        code_next = SCIA_ALM_NONE;
        for (int i = SCIA_NUM_ALM - 1; i >= 0; i--) begin
            if (alm_next[i]) begin
                code_next = src_code(i);
            end
        end
    end

    // registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            comm_input_bits_reg <= SCIA_COMM_IN_RESET;
            reg_rdata_reg <= 16'h0000;
            reg_ack_reg <= 1'b0;
            eff_reg <= 16'h0000;
            rst_in_reg <= 1'b0;
            alm_reg <= '0;
            fault_reg <= 1'b0;
            code_reg <= SCIA_ALM_NONE;
            normal_reg <= 1'b1;
            axis_reg <= AXIS_CODE;
        end else begin
            comm_input_bits_reg <= comm_input_bits_next;
            reg_rdata_reg <= reg_rdata_next;
            reg_ack_reg <= reg_wr || reg_rd;
            eff_reg <= eff_next;
            rst_in_reg <= eff_reg[SCIA_BIT_FAULT_RST];
            alm_reg <= alm_next;
            fault_reg <= |alm_next;
            code_reg <= code_next;
            normal_reg <= !(|alm_next);
            axis_reg <= AXIS_CODE;
        end
    end

    assign reg_rdata = reg_rdata_reg;
    assign reg_ack = reg_ack_reg;
    assign eff_inputs = eff_reg;
    assign fault_output = fault_reg;
    assign coast_stop = fault_reg;
    assign alarm_code = code_reg;
    assign normal_status = normal_reg;
    assign axis_letter = axis_reg;

    // fault output follows latch state
    property p_fault_follows;
        @(posedge core_clk) disable iff (!rst_n)
        (|alm_reg) |-> fault_output;
    endproperty
    a_fault_follows: assert property (p_fault_follows) else $error("fault low with alarm");

    property p_no_alarm_low;
        @(posedge core_clk) disable iff (!rst_n)
        !(|alm_reg) |-> !fault_output && normal_status;
    endproperty
    a_no_alarm_low: assert property (p_no_alarm_low) else $error("fault high without alarm");

    property p_coast;
        @(posedge core_clk) disable iff (!rst_n)
        (|alm_reg) |-> coast_stop;
    endproperty
    a_coast: assert property (p_coast) else $error("alarm without coast");

    property p_latched_stay;
        @(posedge core_clk) disable iff (!rst_n)
        alm_reg[SCIA_SRC_OVERVOLT] |=> alm_reg[SCIA_SRC_OVERVOLT];
    endproperty
    a_latched_stay: assert property (p_latched_stay) else $error("overvolt cleared");

    property p_hall;
        @(posedge core_clk) disable iff (!rst_n)
        (hall_uvw == 3'b111) |=> alm_reg[SCIA_SRC_HALL] ##1 fault_output;
    endproperty
    a_hall: assert property (p_hall) else $error("hall code not flagged");

    property p_dev_big;
        @(posedge core_clk) disable iff (!rst_n)
        (pos_dev > dev_limit) |=> alm_reg[SCIA_SRC_DEV_BIG];
    endproperty
    a_dev_big: assert property (p_dev_big) else $error("deviation alarm missed");

    property p_dev_ovf;
        @(posedge core_clk) disable iff (!rst_n)
        dev_ovf |=> alm_reg[SCIA_SRC_DEV_OVF];
    endproperty
    a_dev_ovf: assert property (p_dev_ovf) else $error("overflow alarm missed");

    property p_hold_no_edge;
        @(posedge core_clk) disable iff (!rst_n)
        alm_reg[SCIA_SRC_ENC_ABC] && !reset_edge |=> alm_reg[SCIA_SRC_ENC_ABC];
    endproperty
    a_hold_no_edge: assert property (p_hold_no_edge) else $error("alarm cleared w/o edge");

    property p_select;
        @(posedge core_clk) disable iff (!rst_n)
        ##1 (eff_inputs ==
            $past((assign_null & comm_input_bits_reg) | (~assign_null & io_connector)));
    endproperty
    a_select: assert property (p_select) else $error("input selection wrong");

    property p_speed;
        @(posedge core_clk) disable iff (!rst_n)
        (speed_abs > speed_limit) |=> alm_reg[SCIA_SRC_OVERSPEED] ##1 (alarm_code != SCIA_ALM_NONE);
    endproperty
    a_speed: assert property (p_speed) else $error("overspeed missed");
endmodule

//--- bench/scia_host_model.sv
// host model: register master that writes and reads the comm input word
`timescale 1ns/100ps
module scia_host_model (
    input wire logic core_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_ack
);
    // idle bus: no strobe, lines parked
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end
    // one transfer: one-cycle strobe, hold address and data until ack is sampled
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic ok);
        ok = 1'b0;
        rdata = 16'h0000;
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = addr;
        reg_wdata = wdata;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // bounded wait for the answer
        for (int n = 0; n < 8 && !ok; n++) begin
            @(posedge core_clk);
            if (reg_ack === 1'b1) begin
                ok = 1'b1;
                rdata = reg_rdata;
            end
        end
        #1;
        // released lines show the inverse so stale values never look valid
        reg_addr = ~addr;
        reg_wdata = ~wdata;
    endtask
endmodule

//--- bench/servo_comm_input_and_alarm_logic_test.sv
// self-checking bench for the comm input word and alarm logic
`timescale 1ns/100ps
module servo_comm_input_and_alarm_logic_test;
    import scia_pkg::*;
    localparam int LOCK_N = 5; // shortened stall time
    localparam int ALM_CODE [12] = '{1, 2, 3, 5, 8, 9, 11, 12, 14, 15, 16, 20}; // codes, ascending
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd, reg_ack;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, eff_inputs;
    logic [15:0] io_connector = 16'h0000;
    logic [15:0] assign_null = 16'h0000;
    logic [15:0] torque = 16'h07d0; // above rated and lock torque
    logic [15:0] speed_abs = 16'h01f4;
    logic [15:0] lock_torque = 16'h03e8;
    logic [15:0] rated_torque = 16'h03e8;
    logic [15:0] speed_limit = 16'h0bb8;
    logic [31:0] pos_dev = 32'h00000000;
    logic [31:0] dev_limit = 32'h00000000;
    logic [23:0] lock_cycles = 24'h000005;
    logic [2:0] hall_uvw = 3'b001; // legal hall code
    logic overload_tmo = 1'b0, dev_ovf = 1'b0, enc_abc_lost = 1'b0, enc_uvw_lost = 1'b0;
    logic boot_fault = 1'b0, overvolt = 1'b0, undervolt = 1'b0, model_fault = 1'b0;
    logic fault_output, coast_stop, normal_status;
    logic [6:0] alarm_code;
    logic [7:0] axis_letter;
    int miscompares = 0;
    int checked = 0;
    int exp_latch [12]; // model of alarm latches
    logic [15:0] word_exp; // model of the comm word
    logic [15:0] rd;
    logic ok;
    // 50 MHz clock
    always #10 core_clk = ~core_clk;
    scia_top #(.TIME_W(24), .AXIS_B(1'b0)) i_scia_top (
        .core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack,
        .io_connector, .assign_null, .eff_inputs, .torque, .lock_torque, .lock_cycles,
        .speed_abs, .rated_torque, .overload_tmo, .speed_limit, .pos_dev, .dev_limit,
        .dev_ovf, .hall_uvw, .enc_abc_lost, .enc_uvw_lost, .boot_fault, .overvolt,
        .undervolt, .model_fault, .fault_output, .coast_stop, .alarm_code, .axis_letter,
        .normal_status
    );
    scia_host_model i_scia_host_model (
        .core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack
    );
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // counts, verdict, end of run
    task automatic close_out();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one bus transfer; a missing ack ends the run
    task automatic bus(input logic wr, input logic [15:0] addr, input logic [15:0] d);
        i_scia_host_model.xfer(wr, addr, d, rd, ok);
        if (!ok) begin
            miscompares++;
            close_out();
        end
    endtask
    // wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // lowest latched code, zero when none
    function automatic int code_exp();
        for (int i = 0; i < 12; i++) begin
            if (exp_latch[i] != 0) return ALM_CODE[i];
        end
        return 0;
    endfunction
    // drive or remove the cause of alarm source i
    task automatic cause(input int i, input logic on);
        case (i)
            0: enc_abc_lost = on;
            1: enc_uvw_lost = on;
            2: overload_tmo = on;
            3: hall_uvw = on ? 3'b111 : 3'b001;
            4: boot_fault = on;
            5: speed_abs = on ? 16'h0009 : 16'h01f4;
            6: overvolt = on;
            7: undervolt = on;
            8: speed_abs = on ? 16'h0bb9 : 16'h01f4;
            9: dev_ovf = on;
            10: pos_dev = on ? dev_limit + 32'h1 : dev_limit;
            default: model_fault = on;
        endcase
    endtask
    // pulse the comm reset bit; source live keeps its cause
    task automatic fault_reset(input int live);
        bus(1'b1, 16'h0451, word_exp | 16'h0010);
        tick(3);
        bus(1'b1, 16'h0451, word_exp);
        tick(3);
        for (int i = 0; i < 12; i++) begin
            if (i != live && !(ALM_CODE[i] inside {8, 9, 11, 12, 20})) exp_latch[i] = 0;
        end
    endtask
    // main sequence
    initial begin
        void'($urandom(41539));
        exp_latch = '{default: 0};
        word_exp = 16'h0000;
        tick(12);
        rst_n = 1'b1;
        check(fault_output, 1'b0);
        check(normal_status, 1'b1);
        check(axis_letter, 8'h41);
        bus(1'b0, 16'h0451, 16'h0000);
        check(rd, 16'h0000);
        $display("test reset done");
        // random words, unmapped neighbour, random selection
        repeat (4) begin
            word_exp = 16'($urandom);
            io_connector = 16'($urandom);
            assign_null = 16'($urandom);
            bus(1'b1, 16'h0451, word_exp);
            bus(1'b1, 16'h0452, ~word_exp);
            bus(1'b0, 16'h0451, 16'h0000);
            check(rd, word_exp);
            bus(1'b0, 16'h0452, 16'h0000);
            check(rd, 16'h0000);
            check(eff_inputs, (assign_null & word_exp) | (~assign_null & io_connector));
        end
        // start bit only counts once its assignment is null
        assign_null = 16'h0000;
        io_connector = 16'h0000;
        bus(1'b1, 16'h0451, 16'h2000);
        tick(2);
        check(eff_inputs, 16'h0000);
        assign_null = 16'h2000;
        bus(1'b1, 16'h0451, 16'h2000);
        tick(2);
        check(eff_inputs, 16'h2000);
        $display("test selection done");
        // every alarm source: raise, refuse clear, clear or keep
        assign_null = 16'hffff;
        word_exp = 16'h0000;
        bus(1'b1, 16'h0451, word_exp);
        dev_limit = {1'b0, 31'($urandom)};
        pos_dev = dev_limit;
        for (int i = 0; i < 13; i++) begin
            cause(i % 12, 1'b1);
            exp_latch[i % 12] = 1;
            if (i == 12) begin
                // short overflow pulse beside the encoder alarm: lowest code shown
                cause(9, 1'b1);
                exp_latch[9] = 1;
                tick(1);
                cause(9, 1'b0);
            end
            tick(LOCK_N + 4);
            check(fault_output, 1'b1);
            check(coast_stop, 1'b1);
            check(normal_status, 1'b0);
            check(alarm_code, code_exp());
            fault_reset(i % 12);
            check(alarm_code, code_exp());
            cause(i % 12, 1'b0);
            cause(0, i == 0 || i == 12 ? 1'b0 : enc_abc_lost);
            fault_reset(-1);
            check(alarm_code, code_exp());
            check(fault_output, code_exp() != 0);
            check(coast_stop, code_exp() != 0);
            check(normal_status, code_exp() == 0);
            if (code_exp() != 0) begin
                rst_n = 1'b0;
                tick(2);
                rst_n = 1'b1;
                exp_latch = '{default: 0};
            end
            check(fault_output, 1'b0);
            check(alarm_code, 7'h00);
        end
        $display("test alarms done");
        close_out();
    end
endmodule
